// [rtl/caci_top.sv]
// Top: three channel change-of-condition interrupt enables and status
`timescale 1ns/1ps
module caci_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Conditions per channel
  input wire caci_pkg::caci_cond_t [2:0] cond_i,
  // Interrupt request
  output logic irq_o
);
  // ------------------------------------------------------------
  // Request carrier
  // ------------------------------------------------------------
  caci_pkg::caci_req_t req_w;
  logic req_wr;
  logic req_rd;
  logic [5:0] req_addr;
  logic [3:0] req_wdata;
  logic rd_fire;

  assign req_w = '{
    wr: reg_wr_i,
    rd: reg_rd_i,
    addr: reg_addr_i,
    wdata: reg_wdata_i
  };
  assign req_wr = req_w.wr;
  assign req_rd = req_w.rd;
  assign req_addr = req_w.addr;
  // Bits 7:4 of a write have no storage behind them
  assign req_wdata = req_w.wdata[3:0];
  assign rd_fire = clk_en_i & req_rd;

  // ------------------------------------------------------------
  // Address map
  // ------------------------------------------------------------
  logic [5:0] en_addr [3];
  logic [5:0] st_addr [3];

  assign en_addr[0] = caci_pkg::ENABLE_ADDR_CH0;
  assign en_addr[1] = caci_pkg::ENABLE_ADDR_CH1;
  assign en_addr[2] = caci_pkg::ENABLE_ADDR_CH2;
  assign st_addr[0] = caci_pkg::STATUS_ADDR_CH0;
  assign st_addr[1] = caci_pkg::STATUS_ADDR_CH1;
  assign st_addr[2] = caci_pkg::STATUS_ADDR_CH2;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic [2:0] en_hit;
  logic [2:0] st_hit;
  logic [2:0] en_wr;
  logic [2:0] st_rd;
  logic any_en_hit;
  logic any_st_hit;
  logic unmapped;

  assign any_en_hit = |en_hit;
  assign any_st_hit = |st_hit;
  // Writes here are dropped and reads return zero
  assign unmapped = ~(any_en_hit | any_st_hit);

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  logic [3:0] enable_w [3];
  logic [3:0] status_w [3];
  logic [2:0] pend_w;
  logic [7:0] en_word [3];
  logic [7:0] st_word [3];
  logic [7:0] sel_word [3];

  for (genvar c = 0; c < 3; c++) begin : g_ch
    assign en_hit[c] = (req_addr == en_addr[c]);
    assign st_hit[c] = (req_addr == st_addr[c]);
    // Status has no write path, so a write there is ignored
    assign en_wr[c] = req_wr & en_hit[c];
    assign st_rd[c] = req_rd & st_hit[c];

    caci_channel u_ch (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .enable_wr_i(en_wr[c]),
      .status_rd_i(st_rd[c]),
      .wdata_i(req_wdata),
      .cond_i(cond_i[c]),
      .enable_o(enable_w[c]),
      .status_o(status_w[c]),
      .pending_o(pend_w[c])
    );

    // Upper nibble of both registers always reads zero
    assign en_word[c] = {4'h0, enable_w[c]};
    assign st_word[c] = {4'h0, status_w[c]};
    assign sel_word[c] = ({8{en_hit[c]}} & en_word[c])
      | ({8{st_hit[c]}} & st_word[c]);
  end

  // ------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------
  logic [7:0] map_word;
  logic [7:0] rdata_next;
  logic rvalid_next;

  // Hits are one-hot, so an OR of the gated words selects
  assign map_word = sel_word[0] | sel_word[1] | sel_word[2];
  assign rdata_next = unmapped ? caci_pkg::RDATA_RESET : map_word;
  assign rvalid_next = req_rd;

  // ------------------------------------------------------------
  // Interrupt request
  // ------------------------------------------------------------
  logic irq_next;

  // Registered so decode glitches never reach the request pin
  assign irq_next = |pend_w;

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic irq_reg;

  // Read data holds until the next read
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= caci_pkg::RDATA_RESET;
    end else if (rd_fire) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rvalid_reg <= caci_pkg::RVALID_RESET;
    end else if (clk_en_i) begin
      rvalid_reg <= rvalid_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_reg <= caci_pkg::IRQ_RESET;
    end else if (clk_en_i) begin
      irq_reg <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign irq_o = irq_reg;
endmodule // caci_top

// [rtl/caci_pkg.sv]
// Package: constants and types for channel alarm change interrupt enables
// Function
// - Enable register per channel at 0x01/0x09/0x11
// - Bit 3 enables fifo limit alarm changes
// - Bit 3 zero suppresses fifo limit interrupts
// - Bit 2 enables loss-of-lock changes
// - Loss-of-lock enable is read/write
// - Bit 1 enables loss-of-signal changes
// - Loss-of-signal enable is read/write
// - Bit 0 enables drive monitor changes
// - Change sets sticky status; read clears it
package caci_pkg;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_COND = 4;
  // Register addresses
  localparam logic [5:0] ENABLE_ADDR_CH0 = 6'h01;
  localparam logic [5:0] ENABLE_ADDR_CH1 = 6'h09;
  localparam logic [5:0] ENABLE_ADDR_CH2 = 6'h11;
  localparam logic [5:0] STATUS_ADDR_CH0 = 6'h02;
  localparam logic [5:0] STATUS_ADDR_CH1 = 6'h0a;
  localparam logic [5:0] STATUS_ADDR_CH2 = 6'h12;
  // Field positions
  localparam int unsigned BIT_DRIVE = 0;
  localparam int unsigned BIT_SIGNAL = 1;
  localparam int unsigned BIT_LOCK = 2;
  localparam int unsigned BIT_FIFO = 3;
  // Reset values
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [3:0] COND_RESET = 4'h0;
  localparam logic RVALID_RESET = 1'b0;
  localparam logic IRQ_RESET = 1'b0;

  typedef struct packed {
    logic fifo_limit_alarm;
    logic receive_lock_lost;
    logic receive_signal_lost;
    logic transmit_drive_monitor_flag;
  } caci_cond_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } caci_req_t;
endpackage

// [rtl/caci_channel.sv]
// Per-channel enable, edge detect and clear-on-read status
`timescale 1ns/1ps
module caci_channel (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Register access
  input wire logic enable_wr_i,
  input wire logic status_rd_i,
  input wire logic [3:0] wdata_i,
  // Conditions
  input wire caci_pkg::caci_cond_t cond_i,
  // State
  output logic [3:0] enable_o,
  output logic [3:0] status_o,
  output logic pending_o
);
  logic [3:0] enable_reg;
  logic [3:0] status_reg;
  logic [3:0] cond_prev_reg;
  logic [3:0] cond_now;
  logic [3:0] change;
  logic [3:0] status_next;

  assign cond_now = cond_i;
  // Either direction of change counts
  assign change = (cond_now ^ cond_prev_reg) & enable_reg;
  // Set wins over the read clear so no event is lost
  assign status_next = change | (status_rd_i ? 4'h0 : status_reg);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      enable_reg <= caci_pkg::ENABLE_RESET;
      status_reg <= caci_pkg::STATUS_RESET;
      cond_prev_reg <= caci_pkg::COND_RESET;
    end else if (clk_en_i) begin
      if (enable_wr_i) begin
        enable_reg <= wdata_i;
      end
      status_reg <= status_next;
      cond_prev_reg <= cond_now;
    end
  end

  assign enable_o = enable_reg;
  assign status_o = status_reg;
  assign pending_o = |(status_reg & enable_reg);
endmodule // caci_channel

// [test/caci_top_checker.sv]
// Checker of the register port and request of the top
`timescale 1ns/1ps
module caci_top_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire caci_pkg::caci_cond_t [2:0] cond_i,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire go = clk_en_i && reg_rd_i;
  wire st = go && reg_addr_i == 6'h02;
  wire w1 = clk_en_i && reg_wr_i && reg_addr_i == 6'h01;
  wire [3:0] wl = reg_wdata_i[3:0];
  chk_read_answer:
    assert property (go |=> reg_rvalid_o) else $error("no answer");
  chk_no_stray:
    assert property (clk_en_i && !reg_rd_i |=> !reg_rvalid_o)
    else $error("stray valid");
  chk_rdata_hold:
    assert property (clk_en_i && !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("rdata moved");
  chk_upper_zero:
    assert property (reg_rvalid_o |-> reg_rdata_o[7:4] == 4'h0)
    else $error("upper bits set");
  chk_unmapped_zero:
    assert property (go && reg_addr_i == 6'h3f |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
  chk_enable_back:
    assert property (w1 ##1 !reg_wr_i ##1 go && reg_addr_i == 6'h01
      && !reg_wr_i |=> reg_rdata_o[3:0] == $past(wl, 3))
    else $error("enable readback");
  chk_read_clears:
    assert property (clk_en_i && $stable(cond_i) ##1 st && $stable(cond_i)
      ##1 clk_en_i && $stable(cond_i) ##1 st |=> reg_rdata_o == 8'h00)
    else $error("status not cleared");
  chk_freeze_hold:
    assert property (!clk_en_i |=> $stable(irq_o) && $stable(reg_rvalid_o)
      && $stable(reg_rdata_o))
    else $error("state moved while frozen");
  chk_reset_quiet:
    assert property ($fell(rst_i) |-> !irq_o && !reg_rvalid_o)
    else $error("reset state");
endmodule // caci_top_checker

bind caci_top caci_top_checker u_chk (.*);

// [test/channel_alarm_change_irq_enable_test.sv]
// Bench: enables, change status and request of three channels
`timescale 1ns/1ps
module channel_alarm_change_irq_enable_test;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_rvalid_o, irq_o;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d, e;
  caci_pkg::caci_cond_t [2:0] cond_i = '0;
  logic [5:0] ea [3] = '{6'h01, 6'h09, 6'h11};
  int n_fail = 0, num_checks = 0, c, b;
  caci_top u_dut (.*);
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] st_exp(logic [7:0] en, int k);
    return {7'h00, en[k]} << k;
  endfunction
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] v);
    @(negedge sys_clk_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, a, v};
    @(negedge sys_clk_i);
    {reg_wr_i, reg_rd_i} = 2'b00;
    d = reg_rdata_o;
    check({7'h00, reg_rvalid_o}, {7'h00, !w});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(94));
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'b0;
    check({7'h00, irq_o}, 8'h00);
    for (c = 0; c < 3; c++) begin
      acc(1'b0, ea[c], 8'h00);
      check(d, 8'h00);
    end
    acc(1'b1, 6'h3f, 8'hff);
    acc(1'b0, 6'h3f, 8'h00);
    check(d, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      c = i / 8;
      b = i % 4;
      // First two passes: all enabled, then the low half masked
      e = i < 2 ? 8'hff << (4 * i) : 8'($urandom);
      acc(1'b1, ea[c], e);
      acc(1'b0, ea[c], 8'h00);
      check(d, e & 8'h0f);
      acc(1'b1, ea[c] + 6'h01, 8'hff);
      cond_i[c][b] = ~cond_i[c][b];
      repeat (3) @(negedge sys_clk_i);
      check({7'h00, irq_o}, {7'h00, e[b]});
      for (int k = 0; k < 2; k++) begin
        acc(1'b0, ea[c] + 6'h01, 8'h00);
        check(d, k ? 8'h00 : st_exp(e, b));
      end
      check({7'h00, irq_o}, 8'h00);
    end
    $display("change test done");
    // Change and read clear on one edge: the set must win
    acc(1'b1, ea[0], 8'h0f);
    @(negedge sys_clk_i);
    {reg_rd_i, reg_addr_i} = {1'b1, ea[0] + 6'h01};
    cond_i[0][0] = ~cond_i[0][0];
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    check(reg_rdata_o, 8'h00);
    acc(1'b0, ea[0] + 6'h01, 8'h00);
    check(d, 8'h01);
    $display("set wins test done");
    // Frozen clock enable: no event, no write, no request
    acc(1'b1, ea[1], 8'h0f);
    clk_en_i = 1'b0;
    cond_i[1][2] = ~cond_i[1][2];
    repeat (4) @(negedge sys_clk_i);
    check({7'h00, irq_o}, 8'h00);
    acc(1'b1, ea[1], 8'h00);
    clk_en_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    check({7'h00, irq_o}, 8'h01);
    acc(1'b0, ea[1], 8'h00);
    check(d, 8'h0f);
    acc(1'b0, ea[1] + 6'h01, 8'h00);
    check(d, 8'h04);
    $display("clock enable test done");
    // Reset in mid-run clears enables, status and request
    cond_i[1][2] = ~cond_i[1][2];
    repeat (3) @(negedge sys_clk_i);
    check({7'h00, irq_o}, 8'h01);
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    check({7'h00, irq_o}, 8'h00);
    acc(1'b0, ea[1] + 6'h01, 8'h00);
    check(d, 8'h00);
    acc(1'b0, ea[1], 8'h00);
    check(d, 8'h00);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule // channel_alarm_change_irq_enable_test
